// file: rtl/clk_rst_map.svh
// Register offsets, field positions, reset values and timing figures of the clock block
`ifndef CLK_RST_MAP_SVH
`define CLK_RST_MAP_SVH

// Register byte offsets
`define PWR_CTRL_OFS    4'h0
`define CLK_STAT_OFS    4'h4

// Power-management control fields
`define MULT_LSB        0
`define MULT_MSB        5
`define DIV_LSB         6
`define DIV_MSB         7
`define HALVE_SEL_BIT   8

// Status fields
`define STAT_LOCK_BIT   0
`define STAT_CORE_BIT   1
`define STAT_MULT_LSB   8
`define STAT_MULT_MSB   13

// Reset values
`define DIV_CODE_RST    2'h0
`define HALVE_SEL_RST   1'h0
`define MULT_RST        6'h00

// Multiplier derived from each strap ratio code
`define STRAP_MULT_00   6'h06
`define STRAP_MULT_01   6'h20
`define STRAP_MULT_10   6'h10
`define STRAP_MULT_11   6'h06

// Timing figures
`define CLK_MHZ         20
`define LOCK_TIME_US    100
`define RST_REF_CYCLES  4096
`define RST_CORE_TICKS  2

`endif

// file: rtl/clk_rst_pkg.sv
// Types shared by the core clock and reset block
package clk_rst_pkg;
	typedef enum logic [1:0] {
		RS_HELD,
		RS_REF_COUNT,
		RS_CORE_COUNT,
		RS_RUN
	} rst_state_e;
	typedef logic [5:0] mult_t;
	typedef logic [1:0] div_code_t;
endpackage

// file: rtl/core_pll_clock_and_reset.sv
// Core clock synthesis, peripheral clock and core reset release
// How it works
// [R1] During reset the multiplier is loaded from the two clock ratio straps.
// [R2] Post divider is 1, 2, 4 or 8 from a control field; 1 in reset.
// [R3] Oscillator runs 2*M*f_in; core clock is that over 2*D.
// [R4] PLL input is the reference clock, or half of it when divide select is 1.
// [R5] Software keeps reference times multiplier within the 800 MHz oscillator limit.
// [R6] Peripheral clock period is exactly two core clock periods.
// [R7] Core reset released 4096 reference cycles plus two core cycles after pin release.
// [R8] After power-up the reset pin is held low at least four reference cycles.
// [R9] Board holds strap settings stable 20 us before reset release.
// [R10] Reference clock is stable at least 10 us before reset release.
// [R11] PLL locks within 100 us while reset is held.
// [R12] Software changes keep the core clock period within its 10 ns maximum.
// [R13] Core and peripheral clocks stay off until the PLL locks again.
`include "clk_rst_map.svh"

module core_pll_clock_and_reset
	import clk_rst_pkg::*;
#(
	parameter int REF_RESET_CYCLES = `RST_REF_CYCLES,
	parameter int LOCK_CYCLES      = `LOCK_TIME_US * `CLK_MHZ,
	parameter int CREDIT_W         = 12
) (
	input  wire logic        CORE_CLK_IN,
	input  wire logic        RST_IN,
	input  wire logic        REFERENCE_CLOCK_INPUT_IN,
	input  wire logic        RESET_PIN_N_IN,
	input  wire logic [1:0]  CLOCK_RATIO_STRAPS_IN,
	input  wire logic [3:0]  ADDR_IN,
	input  wire logic [31:0] WDATA_IN,
	input  wire logic        WE_IN,
	input  wire logic        RE_IN,
	output logic      [31:0] RDATA_OUT,
	output logic             CORE_CLK_EN_OUT,
	output logic             PERIPH_CLK_EN_OUT,
	output logic             CORE_RESET_N_OUT,
	output logic             PLL_LOCKED_OUT
);

	localparam int RC_W = $clog2(REF_RESET_CYCLES + 2);
	localparam int LC_W = $clog2(LOCK_CYCLES + 1);

	logic [3:0]          pin_vec;
	logic [3:0]          sync1_q;
	logic [3:0]          sync2_q;
	logic                ref_d3_q;
	logic                ref_rise;
	logic                half_q;
	logic                pll_in_tick;
	logic                pin_low;
	mult_t               strap_mult;
	mult_t               mult_q;
	div_code_t           div_code_q;
	logic                halve_sel_q;
	logic                cfg_wr;
	logic                cfg_chg;
	logic                relock;
	logic [LC_W-1:0]     lock_cnt_q;
	logic                locked_q;
	logic [CREDIT_W-1:0] div_val;
	logic [CREDIT_W-1:0] credit_q;
	logic [CREDIT_W:0]   credit_sum;
	logic                tick;
	logic                core_tick_q;
	logic                periph_ph_q;
	logic                periph_tick_q;
	rst_state_e          rst_state_q;
	logic [RC_W-1:0]     ref_cnt_q;
	logic [1:0]          core_cnt_q;
	logic                core_rst_n_q;
	logic [31:0]         rdata_q;

	// Two-stage synchroniser for every pin input, one lane per pin
	assign pin_vec = {CLOCK_RATIO_STRAPS_IN, RESET_PIN_N_IN, REFERENCE_CLOCK_INPUT_IN};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			always_ff @(posedge CORE_CLK_IN) begin
				if (RST_IN) begin
					sync1_q[gi] <= 1'b0;
					sync2_q[gi] <= 1'b0;
				end else begin
					sync1_q[gi] <= pin_vec[gi];
					sync2_q[gi] <= sync1_q[gi];
				end
			end
		end
	endgenerate

	// Reference edge detect on the synchronised level
	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN) begin
			ref_d3_q <= 1'b0;
		end else begin
			ref_d3_q <= sync2_q[0];
		end
	end
	assign ref_rise = sync2_q[0] & ~ref_d3_q;
	assign pin_low  = ~sync2_q[1]; // R8

	// Optional halving of the reference into the PLL
	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN) begin
			half_q <= 1'b0;
		end else if (ref_rise) begin
			half_q <= ~half_q;
		end
	end
	assign pll_in_tick = ref_rise & (~halve_sel_q | half_q); // R4

	// Strap ratio decode
	always_comb begin
		unique case (sync2_q[3:2])
			2'h0: strap_mult = `STRAP_MULT_00;
			2'h1: strap_mult = `STRAP_MULT_01;
			2'h2: strap_mult = `STRAP_MULT_10;
			2'h3: strap_mult = `STRAP_MULT_11;
		endcase
	end

	// Power-management control register
	assign cfg_wr  = WE_IN & (ADDR_IN == `PWR_CTRL_OFS) & ~pin_low;
	assign cfg_chg = cfg_wr & ((WDATA_IN[`MULT_MSB:`MULT_LSB] != mult_q) |
	                           (WDATA_IN[`DIV_MSB:`DIV_LSB] != div_code_q) |
	                           (WDATA_IN[`HALVE_SEL_BIT] != halve_sel_q));
	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN) begin
			mult_q      <= `MULT_RST;
			div_code_q  <= `DIV_CODE_RST;
			halve_sel_q <= `HALVE_SEL_RST;
		end else if (pin_low) begin
			mult_q      <= strap_mult; // R1
			div_code_q  <= `DIV_CODE_RST; // R2
			halve_sel_q <= `HALVE_SEL_RST; // R4
		end else if (cfg_wr) begin
			mult_q      <= WDATA_IN[`MULT_MSB:`MULT_LSB];
			div_code_q  <= WDATA_IN[`DIV_MSB:`DIV_LSB]; // R2
			halve_sel_q <= WDATA_IN[`HALVE_SEL_BIT]; // R4
		end
	end

	// Lock timer, restarted by a write that changes a control field or by a strap multiplier change while the pin is low
	assign relock = cfg_chg | (pin_low & (strap_mult != mult_q));
	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN || relock) begin
			lock_cnt_q <= '0;
			locked_q   <= 1'b0; // R13
		end else if (!locked_q) begin
			lock_cnt_q <= lock_cnt_q + 1'b1;
			locked_q   <= (lock_cnt_q == LC_W'(LOCK_CYCLES - 1)); // R11
		end
	end

	// Rate synthesis: credit M per PLL input edge, spend D per core tick
	assign div_val    = CREDIT_W'(1) << div_code_q; // R2
	assign tick       = locked_q & (credit_q >= div_val); // R3 R13
	assign credit_sum = {1'b0, credit_q} + (pll_in_tick ? (CREDIT_W+1)'(mult_q) : '0)
	                    - (tick ? {1'b0, div_val} : '0);
	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN || !locked_q) begin
			credit_q <= '0;
		end else if (credit_sum[CREDIT_W]) begin
			credit_q <= '1; // Saturate rather than wrap
		end else begin
			credit_q <= credit_sum[CREDIT_W-1:0]; // R3
		end
	end

	// Core tick and peripheral tick at half the core rate
	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN) begin
			core_tick_q   <= 1'b0;
			periph_ph_q   <= 1'b0;
			periph_tick_q <= 1'b0;
		end else begin
			core_tick_q   <= tick;
			periph_tick_q <= tick & periph_ph_q; // R6
			if (!locked_q) begin
				periph_ph_q <= 1'b0;
			end else if (tick) begin
				periph_ph_q <= ~periph_ph_q;
			end
		end
	end

	// Core reset release sequencer
	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN || pin_low) begin
			rst_state_q  <= RS_HELD;
			ref_cnt_q    <= '0;
			core_cnt_q   <= '0;
			core_rst_n_q <= 1'b0;
		end else begin
			unique case (rst_state_q)
				RS_HELD: begin
					rst_state_q <= RS_REF_COUNT;
				end
				RS_REF_COUNT: begin
					if (ref_rise) begin
						ref_cnt_q <= ref_cnt_q + 1'b1;
						if (ref_cnt_q == RC_W'(REF_RESET_CYCLES - 1)) begin
							rst_state_q <= RS_CORE_COUNT; // R7
						end
					end
				end
				RS_CORE_COUNT: begin
					if (tick) begin
						core_cnt_q <= core_cnt_q + 1'b1;
						if (core_cnt_q == 2'(`RST_CORE_TICKS - 1)) begin
							rst_state_q  <= RS_RUN;
							core_rst_n_q <= 1'b1; // R7
						end
					end
				end
				RS_RUN: begin
					core_rst_n_q <= 1'b1;
				end
			endcase
		end
	end

	// Register read port, data in the cycle after the strobe
	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= '0;
			if (RE_IN) begin
				unique case (ADDR_IN)
					`PWR_CTRL_OFS: begin
						rdata_q[`MULT_MSB:`MULT_LSB] <= mult_q;
						rdata_q[`DIV_MSB:`DIV_LSB]   <= div_code_q;
						rdata_q[`HALVE_SEL_BIT]      <= halve_sel_q;
					end
					`CLK_STAT_OFS: begin
						rdata_q[`STAT_LOCK_BIT]                <= locked_q;
						rdata_q[`STAT_CORE_BIT]                <= core_rst_n_q;
						rdata_q[`STAT_MULT_MSB:`STAT_MULT_LSB] <= mult_q;
					end
					default: begin
						rdata_q <= '0;
					end
				endcase
			end
		end
	end

	// Output drive
	assign RDATA_OUT         = rdata_q;
	assign CORE_CLK_EN_OUT   = core_tick_q;
	assign PERIPH_CLK_EN_OUT = periph_tick_q;
	assign CORE_RESET_N_OUT  = core_rst_n_q;
	assign PLL_LOCKED_OUT    = locked_q;

	// Helper counters watched by the checks
	logic [LC_W:0] unlock_run_q;
	logic [RC_W:0] ref_seen_q;
	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN || relock || locked_q) begin
			unlock_run_q <= '0;
		end else begin
			unlock_run_q <= unlock_run_q + 1'b1;
		end
		if (RST_IN || pin_low) begin
			ref_seen_q <= '0;
		end else if (ref_rise && !core_rst_n_q) begin
			ref_seen_q <= ref_seen_q + 1'b1;
		end
	end

	default clocking cb @(posedge CORE_CLK_IN); endclocking
	default disable iff (RST_IN);

	// Checks beside the logic
	a_strap_mult_load: assert property (pin_low |=> mult_q == $past(strap_mult)) // R1
		else $error("multiplier not taken from straps in reset");
	a_div_one_reset: assert property (pin_low |=> div_code_q == 2'h0 && div_val == 1) // R2
		else $error("post divider not 1 during reset");
	a_rate_div_one: assert property ((locked_q && pll_in_tick && mult_q != 0 && div_code_q == 2'h0
		&& !relock) |=> (!locked_q || tick)) // R3
		else $error("core tick missing after credit with divider 1");
	a_input_halved: assert property ((halve_sel_q && pll_in_tick) |-> ref_rise && half_q) // R4
		else $error("PLL input tick not halved");
	a_periph_half: assert property (periph_tick_q |-> core_tick_q ##1 !periph_tick_q[*1]) // R6
		else $error("peripheral tick not on alternate core tick");
	a_core_release: assert property ($rose(core_rst_n_q) |-> ref_seen_q >= REF_RESET_CYCLES
		&& ref_seen_q <= REF_RESET_CYCLES + 1) // R7
		else $error("core reset released at wrong reference count");
	a_reset_holds: assert property (pin_low |=> !core_rst_n_q) // R7
		else $error("core reset not held while pin low");
	a_lock_bound: assert property (unlock_run_q <= LOCK_CYCLES) // R11
		else $error("PLL lock took longer than allowed");
	a_no_clock_unlocked: assert property (core_tick_q |-> $past(locked_q)) // R13
		else $error("core tick while PLL unlocked");
	a_relock_drop: assert property (cfg_chg |=> !locked_q && !tick) // R13
		else $error("clocks not stopped on ratio change");

	c_core_released: cover property ($rose(core_rst_n_q));
	c_periph_tick: cover property (periph_tick_q);
	c_relock_done: cover property (cfg_chg ##[1:1000] $rose(locked_q));
	c_halved_input: cover property (halve_sel_q && pll_in_tick && locked_q);

endmodule

// file: verif/board_model.sv
// Board side model: reference oscillator, reset source and ratio straps
module board_model (
	input  wire logic       clk_in,
	input  wire logic       hold_in,
	input  wire logic [1:0] straps_req_in,
	output logic            ref_out,
	output logic            pin_n_out,
	output logic [1:0]      straps_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] div_q = 2'h0;
	logic       ref_q = 1'b0;
	logic [2:0] low_q = 3'h0;
	logic [1:0] straps_q = 2'h0;
	// Free running reference, three system cycles high and three low
	always @(posedge clk_in) begin
		if (div_q == 2'h2) begin
			div_q <= 2'h0;
			ref_q <= ~ref_q;
		end else begin
			div_q <= div_q + 2'h1;
		end
	end
	// Pin stays low for at least four reference rises once pulled low
	always @(posedge ref_q) begin
		if (hold_in) begin
			low_q <= 3'h0;
		end else if (low_q != 3'h4) begin
			low_q <= low_q + 3'h1;
		end
	end
	// Straps move only while the pin is low, long before its release
	always @(posedge clk_in) begin
		if (!pin_n_out) begin
			straps_q <= straps_req_in;
		end
	end
	assign ref_out    = ref_q;
	assign pin_n_out  = (low_q == 3'h4);
	assign straps_out = straps_q;
endmodule

// file: verif/core_pll_clock_and_reset_tb.sv
// Self-checking testbench of the core clock and reset block
`include "clk_rst_map.svh"
module core_pll_clock_and_reset_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        hold = 1'b1;
	logic [1:0]  straps_req = 2'h0;
	logic [3:0]  addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic        we = 1'b0;
	logic        re = 1'b0;
	logic        ref_w;
	logic        pin_n;
	logic [1:0]  straps;
	logic [31:0] rdata;
	logic        core_en;
	logic        per_en;
	logic        core_rst_n;
	logic        locked;
	int          n_mismatch = 0;
	int          comparisons = 0;
	int          cyc = 0;
	logic [5:0]  smult [4] = '{`STRAP_MULT_00, `STRAP_MULT_01, `STRAP_MULT_10, `STRAP_MULT_11};
	// System clock, 50 ns period
	always #25 clk = ~clk;
	board_model board (.clk_in(clk), .hold_in(hold), .straps_req_in(straps_req),
		.ref_out(ref_w), .pin_n_out(pin_n), .straps_out(straps));
	core_pll_clock_and_reset #(.REF_RESET_CYCLES(8), .LOCK_CYCLES(10)) dut (
		.CORE_CLK_IN(clk), .RST_IN(rst), .REFERENCE_CLOCK_INPUT_IN(ref_w),
		.RESET_PIN_N_IN(pin_n), .CLOCK_RATIO_STRAPS_IN(straps), .ADDR_IN(addr),
		.WDATA_IN(wdata), .WE_IN(we), .RE_IN(re), .RDATA_OUT(rdata),
		.CORE_CLK_EN_OUT(core_en), .PERIPH_CLK_EN_OUT(per_en),
		.CORE_RESET_N_OUT(core_rst_n), .PLL_LOCKED_OUT(locked));
	task automatic results();
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		we    <= 1'b1;
		@(posedge clk);
		we    <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		re   <= 1'b1;
		@(posedge clk);
		re   <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
	// Pin low: multiplier follows straps, writes ignored, lock reached
	task automatic strap_scan();
		logic [31:0] d;
		for (int i = 0; i < 4; i++) begin
			straps_req <= i[1:0];
			repeat (16) @(posedge clk);
			rd(`CLK_STAT_OFS, d);
			check("strap multiplier", {26'h0, d[13:8]}, {26'h0, smult[i]});
		end
		wr(`PWR_CTRL_OFS, 32'h1c3);
		rd(`PWR_CTRL_OFS, d);
		check("divider in reset", {30'h0, d[7:6]}, 32'h0);
		check("core reset held", {31'h0, core_rst_n}, 32'h0);
		check("lock in reset", {31'h0, locked}, 32'h1);
	endtask
	// Count reference rises from pin release to core reset release
	// The rise that lifts the pin is counted too, hence one above the cycle count
	task automatic release_reset();
		int   n;
		logic pr;
		n  = 0;
		pr = 1'b1;
		straps_req <= 2'h2;
		repeat (16) @(posedge clk);
		hold <= 1'b0;
		for (int k = 0; k < 400 && core_rst_n !== 1'b1; k++) begin
			@(negedge clk);
			if (pin_n && ref_w && !pr) n++;
			pr = ref_w;
		end
		check("release ref count", {31'h0, n >= 9 && n <= 10}, 32'h1);
	endtask
	// Program M=4 with a divider and optional input halving, then measure tick rates
	task automatic rate(input logic ind, input logic [1:0] dc);
		int          nr;
		int          nc;
		int          np;
		int          ex;
		logic        pr;
		logic [31:0] d;
		nr = 0;
		nc = 0;
		np = 0;
		pr = 1'b1;
		ex = (64 >> dc) >> ind;
		wr(`PWR_CTRL_OFS, {23'h0, ind, dc, 6'h04});
		@(posedge clk);
		@(negedge clk);
		check("lock drop", {31'h0, locked}, 32'h0);
		for (int k = 0; k < 60 && locked !== 1'b1; k++) begin
			check("tick while unlocked", {30'h0, core_en, per_en}, 32'h0);
			@(negedge clk);
		end
		check("relock", {31'h0, locked}, 32'h1);
		for (int k = 0; k < 300 && nr < 17; k++) begin
			@(negedge clk);
			if (ref_w && !pr) nr++;
			pr = ref_w;
			if (nr >= 1) nc += int'(core_en);
			if (nr >= 1) np += int'(per_en);
			if (per_en && !core_en) check("periph alone", 32'h1, 32'h0);
		end
		check("core rate", {31'h0, nc - ex <= 1 && ex - nc <= 1}, 32'h1);
		check("periph rate", {31'h0, 2 * np - nc <= 1 && nc - 2 * np <= 1}, 32'h1);
		rd(`PWR_CTRL_OFS, d);
		check("control readback", {23'h0, d[8:0]}, {23'h0, ind, dc, 6'h04});
	endtask
	// Stray writes, status flags and an unmapped read
	task automatic regs();
		logic [31:0] d;
		wr(`CLK_STAT_OFS, 32'hffffffff);
		wr(4'hc, 32'hffffffff);
		rd(`PWR_CTRL_OFS, d);
		check("control kept", {23'h0, d[8:0]}, 32'h1c4);
		rd(`CLK_STAT_OFS, d);
		check("status flags", {30'h0, d[1:0]}, 32'h3);
		rd(4'hc, d);
		check("unmapped read", d, 32'h0);
	endtask
	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			results();
		end
	end
	// Main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		strap_scan();
		release_reset();
		for (int i = 0; i < 8; i++) rate(i[2], i[1:0]);
		regs();
		hold <= 1'b1;
		strap_scan();
		results();
	end
endmodule
